// >>> core/ptc_controller.sv
// paper tape reader and punch controller on the programmed i/o bus
// Functional notes
// - transmitter answers even non-zero address; receiver at next odd address
// - receiver latches each reader byte, overwriting; data-in drives it
// - data-in byte goes on lines 8..15, msb on line 8
// - one punch cycle per accepted byte, at most 60 per second
// - command strobe decodes accumulator low byte, acknowledges valid codes
// - codes 01,02,04,05,06,08,09,0a map start/stop/inhibit/allow combinations
// - stop lets one more character arrive, then halts reader
// - inhibit/allow act on either section; others only on receiver
// - interrupt mode: request per character until data, address or status
// - character overrun sets timing error; data-in unacknowledged until cleared
// - any receiver command or receiver status-in clears timing error
// - with timing error data-in drives buffer, no ack, clears request
// - start while not ready acknowledged, raises request; data-in unacknowledged
// - no data-in ack without a new character since last transfer
// - transmitter requests after each byte to punch, until accepted data-out, address or status
// - data-out while punch not ready: no ack, request if allowed, byte punched
// - that request clears on address/status; not-ready resets on status once ready
// - non-interrupt receiver: request and address-in answer only after start while not ready; one ack per char
// - non-interrupt transmitter acknowledges, punches, refuses while still punching
// - data-out byte from lines 8..15; ack only when accepted and ready
// - address-in drives requesting section address, no acknowledge
// - status-in drives status byte, no ack: 40 not ready, 04 timing
// - reader/punch not-ready from power, switch, rewind, tape end inputs
// - status-in clears request and status of addressed section
// - address-in only with priority grant; ends request, keeps need
// - inhibit drops request but remembers need; allow re-raises it
`timescale 1ns/1ps
`include "ptc_params.svh"
module ptc_controller #(
   parameter logic [7:0] STATION_ADDR = `PTC_DEF_STATION,
   parameter int unsigned PUNCH_GAP_CYCLES = `PTC_PUNCH_GAP_CYCLES
) (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic [7:0] dev_addr_i,
   input wire logic [15:0] bus_i,
   input wire logic cmd_strobe_i,
   input wire logic data_in_strobe_i,
   input wire logic data_out_strobe_i,
   input wire logic addr_in_strobe_i,
   input wire logic status_in_strobe_i,
   input wire logic rx_prio_i,
   input wire logic tx_prio_i,
   output logic [15:0] bus_o,
   output logic bus_oe_o,
   output logic ack_o,
   output logic rx_irq_o,
   output logic tx_irq_o,
   input wire logic rdr_char_strobe_i,
   input wire logic [7:0] rdr_char_i,
   input wire logic rdr_power_ok_i,
   input wire logic rdr_load_pos_i,
   input wire logic rdr_rewinding_i,
   output logic rdr_run_o,
   input wire logic pun_power_ok_i,
   input wire logic pun_out_of_tape_i,
   input wire logic pun_near_end_i,
   input wire logic pun_done_i,
   output logic [7:0] pun_data_o,
   output logic pun_start_o
);
   import ptc_pkg::*;

   // ---------------------------------------------
   // elaboration checks
   // ---------------------------------------------
   // even non-zero station
   initial begin
      if (STATION_ADDR[0] || STATION_ADDR == 8'h00) begin
         $error("station address must be even and non-zero");
      end
      if (PUNCH_GAP_CYCLES < 1) begin
         $error("punch gap must be at least one cycle");
      end
   end

   localparam logic [7:0] RX_ADDR = STATION_ADDR | `PTC_RX_ADDR_BIT;

   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   // bus line 8 carries the msb, so bytes are mirrored
   function automatic logic [7:0] mirror(input logic [7:0] b);
      logic [7:0] r;
      r = '0;
      for (int i = 0; i < 8; i++) begin
         r[i] = b[7 - i];
      end
      return r;
   endfunction : mirror

   function automatic cmd_t cmd_decode(input logic [7:0] c);
      cmd_t r;
      r = '0;
      case (c)
         `PTC_CMD_START: r = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
         `PTC_CMD_STOP: r = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
         `PTC_CMD_INHIBIT: r = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
         `PTC_CMD_START_INH: r = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
         `PTC_CMD_STOP_INH: r = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
         `PTC_CMD_ALLOW: r = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
         `PTC_CMD_START_ALW: r = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
         `PTC_CMD_STOP_ALW: r = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
         default: r = '0;
      endcase
      return r;
   endfunction : cmd_decode

   // ---------------------------------------------
   // state
   // ---------------------------------------------
   typedef struct packed {
      logic [7:0] rx_buf;
      logic rx_new;
      logic rx_terr;
      logic rx_dnr;
      logic rx_run;
      logic rx_stop_pend;
      logic [7:0] tx_byte;
      tx_state_t tx_state;
      logic tx_dnr;
      logic tx_start;
      logic ack;
      logic bus_oe;
      logic [15:0] bus_data;
   } ctl_state_t;

   ctl_state_t q, d;
   section_if rx_s ();
   section_if tx_s ();
   logic pace_busy;
   logic rx_sel;
   logic tx_sel;
   logic rdr_not_ready;
   logic pun_not_ready;
   logic took;
   cmd_t cmd;

   ptc_irq_section #(
      .XFER_CLEARS_FORCE(1'b1)
   ) u_rx_sec (
      .clock_i(clock_i),
      .resetn_i(resetn_i),
      .s(rx_s.sec)
   );

   ptc_irq_section #(
      .XFER_CLEARS_FORCE(1'b0)
   ) u_tx_sec (
      .clock_i(clock_i),
      .resetn_i(resetn_i),
      .s(tx_s.sec)
   );

   ptc_pace_timer #(
      .GAP_CYCLES(PUNCH_GAP_CYCLES)
   ) u_pace (
      .clock_i(clock_i),
      .resetn_i(resetn_i),
      .start_i(q.tx_start),
      .busy_o(pace_busy)
   );

   // ---------------------------------------------
   // decode and readiness
   // ---------------------------------------------
   // address match
   assign rx_sel = (dev_addr_i == RX_ADDR);
   assign tx_sel = (dev_addr_i == STATION_ADDR);
   assign cmd = cmd_decode(mirror(bus_i[15:8]));
   assign rdr_not_ready = !rdr_power_ok_i | rdr_load_pos_i | rdr_rewinding_i;
   assign pun_not_ready = !pun_power_ok_i | pun_out_of_tape_i | pun_near_end_i;

   // ---------------------------------------------
   // controller next state
   // ---------------------------------------------
   always_comb begin
      d = q;
      d.ack = 1'b0;
      d.bus_oe = 1'b0;
      d.bus_data = '0;
      d.tx_start = 1'b0;
      took = 1'b0;
      rx_s.event_set = 1'b0;
      rx_s.force_set = 1'b0;
      rx_s.clr_xfer = 1'b0;
      rx_s.clr_query = 1'b0;
      rx_s.clr_status = 1'b0;
      rx_s.do_inhibit = 1'b0;
      rx_s.do_allow = 1'b0;
      tx_s.event_set = 1'b0;
      tx_s.force_set = 1'b0;
      tx_s.clr_xfer = 1'b0;
      tx_s.clr_query = 1'b0;
      tx_s.clr_status = 1'b0;
      tx_s.do_inhibit = 1'b0;
      tx_s.do_allow = 1'b0;

      // command strobe
      if (cmd_strobe_i && (rx_sel || tx_sel)) begin
         d.ack = cmd.valid;
         if (rx_sel) begin
            rx_s.do_inhibit = cmd.inhibit;
            rx_s.do_allow = cmd.allow;
            d.rx_terr = 1'b0;
            if (cmd.start) begin
               if (rdr_not_ready) begin
                  rx_s.force_set = 1'b1;
                  d.rx_dnr = 1'b1;
               end else begin
                  d.rx_run = 1'b1;
                  d.rx_stop_pend = 1'b0;
               end
            end
            if (cmd.stop && q.rx_run) begin
               d.rx_stop_pend = 1'b1;
            end
         end else begin
            tx_s.do_inhibit = cmd.inhibit;
            tx_s.do_allow = cmd.allow;
         end
      end

      // data-in strobe
      if (data_in_strobe_i && rx_sel) begin
         d.bus_oe = 1'b1;
         d.bus_data[15:8] = mirror(q.rx_buf);
         // transfer clears request even if refused
         rx_s.clr_xfer = 1'b1;
         if (!q.rx_terr && !q.rx_dnr && q.rx_new) begin
            d.ack = 1'b1;
            d.rx_new = 1'b0;
            took = 1'b1;
         end
      end

      // data-out strobe
      if (data_out_strobe_i && tx_sel) begin
         if (q.tx_state == TX_IDLE && !pace_busy) begin
            d.tx_byte = mirror(bus_i[15:8]);
            d.tx_state = TX_PUNCH;
            d.tx_start = 1'b1;
            if (pun_not_ready) begin
               // no ack, request at once if allowed
               d.tx_dnr = 1'b1;
               tx_s.force_set = tx_s.allowed;
            end else begin
               d.ack = 1'b1;
               tx_s.clr_xfer = 1'b1;
            end
         end
      end

      // address-in strobe
      if (addr_in_strobe_i) begin
         if (rx_s.irq && rx_prio_i) begin
            d.bus_oe = 1'b1;
            d.bus_data[15:8] = mirror(RX_ADDR);
            rx_s.clr_query = 1'b1;
         end else if (tx_s.irq && tx_prio_i) begin
            d.bus_oe = 1'b1;
            d.bus_data[15:8] = mirror(STATION_ADDR);
            tx_s.clr_query = 1'b1;
         end
      end

      // status-in strobe
      if (status_in_strobe_i && rx_sel) begin
         d.bus_oe = 1'b1;
         d.bus_data[15:8] = mirror(
            (q.rx_dnr ? `PTC_STAT_NOT_READY : `PTC_STAT_NONE) |
            (q.rx_terr ? `PTC_STAT_TIMING_ERR : `PTC_STAT_NONE));
         d.rx_terr = 1'b0;
         d.rx_dnr = rdr_not_ready;
         rx_s.clr_status = 1'b1;
      end
      if (status_in_strobe_i && tx_sel) begin
         d.bus_oe = 1'b1;
         d.bus_data[15:8] = mirror(
            (q.tx_dnr | pun_not_ready) ? `PTC_STAT_NOT_READY : `PTC_STAT_NONE);
         d.tx_dnr = pun_not_ready;
         tx_s.clr_status = 1'b1;
      end

      // reader character arrival; sets win over clears above
      if (rdr_char_strobe_i) begin
         d.rx_buf = rdr_char_i;
         d.rx_new = 1'b1;
         rx_s.event_set = 1'b1;
         if (q.rx_new && !took) begin
            d.rx_terr = 1'b1;
         end
         if (q.rx_stop_pend) begin
            d.rx_run = 1'b0;
            d.rx_stop_pend = 1'b0;
         end
      end

      // reader dropping out is remembered until status-in
      if (rdr_not_ready) begin
         d.rx_dnr = 1'b1;
      end

      // punch cycle completion
      case (q.tx_state)
         TX_IDLE: begin
            d.tx_state = d.tx_state;
         end
         TX_PUNCH: begin
            if (pun_done_i) begin
               d.tx_state = TX_IDLE;
               tx_s.event_set = 1'b1;
            end
         end
         default: begin
            d.tx_state = TX_IDLE;
         end
      endcase
   end

   // ---------------------------------------------
   // registers
   // ---------------------------------------------
   // reset: reader stopped, no error, nothing pending
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // ---------------------------------------------
   // outputs
   // ---------------------------------------------
   // answers stand for one cycle after the strobe
   assign bus_o = q.bus_data;
   assign bus_oe_o = q.bus_oe;
   assign ack_o = q.ack;
   assign rx_irq_o = rx_s.irq;
   assign tx_irq_o = tx_s.irq;
   assign rdr_run_o = q.rx_run;
   assign pun_data_o = q.tx_byte;
   assign pun_start_o = q.tx_start;
endmodule : ptc_controller

// >>> core/ptc_irq_section.sv
// interrupt request logic of one controller section
`timescale 1ns/1ps
module ptc_irq_section #(
   parameter bit XFER_CLEARS_FORCE = 1'b1
) (
   input wire logic clock_i,
   input wire logic resetn_i,
   section_if.sec s
);
   import ptc_pkg::*;
   sec_state_t q, d;
   // ---------------------------------------------
   // request bookkeeping
   // ---------------------------------------------
   always_comb begin
      d = q;
      if (s.do_inhibit) begin
         d.allow = 1'b0;
         d.req = 1'b0;
      end
      if (s.do_allow) begin
         d.allow = 1'b1;
         d.req = q.need;
      end
      if (s.clr_query) begin
         d.req = 1'b0;
         d.force_req = 1'b0;
      end
      if (s.clr_xfer || s.clr_status) begin
         d.need = 1'b0;
         d.req = 1'b0;
      end
      if (s.clr_status || (s.clr_xfer && XFER_CLEARS_FORCE && q.allow)) begin
         d.force_req = 1'b0;
      end
      // new events win over same-cycle clears
      if (s.event_set) begin
         d.need = 1'b1;
         d.req = 1'b1;
      end
      if (s.force_set) begin
         d.force_req = 1'b1;
      end
   end
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
   assign s.irq = (q.req & q.allow) | q.force_req;
   assign s.allowed = q.allow;
endmodule : ptc_irq_section

// >>> core/ptc_pace_timer.sv
// least-spacing timer between punch cycles
`timescale 1ns/1ps
module ptc_pace_timer #(
   parameter int unsigned GAP_CYCLES = 2083334
) (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic start_i,
   output logic busy_o
);
   typedef struct packed {
      logic [31:0] count;
   } pace_state_t;
   pace_state_t q, d;
   initial begin
      if (GAP_CYCLES < 1) begin
         $error("pace gap must be at least one cycle");
      end
   end
   // reload on start, else count down to zero
   always_comb begin
      d = q;
      if (start_i) begin
         d.count = 32'(GAP_CYCLES);
      end else if (q.count != 32'h0) begin
         d.count = q.count - 32'h1;
      end
   end
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
   assign busy_o = (q.count != 32'h0);
endmodule : ptc_pace_timer

// >>> core/ptc_params.svh
// constants for the paper tape reader and punch controller
`ifndef PTC_PARAMS_SVH
`define PTC_PARAMS_SVH
// ---------------------------------------------
// command codes (low byte of the accumulator)
// ---------------------------------------------
`define PTC_CMD_START 8'h01
`define PTC_CMD_STOP 8'h02
`define PTC_CMD_INHIBIT 8'h04
`define PTC_CMD_START_INH 8'h05
`define PTC_CMD_STOP_INH 8'h06
`define PTC_CMD_ALLOW 8'h08
`define PTC_CMD_START_ALW 8'h09
`define PTC_CMD_STOP_ALW 8'h0a
// ---------------------------------------------
// status bytes and addressing
// ---------------------------------------------
`define PTC_STAT_NOT_READY 8'h40
`define PTC_STAT_TIMING_ERR 8'h04
`define PTC_STAT_NONE 8'h00
`define PTC_RX_ADDR_BIT 8'h01
`define PTC_DEF_STATION 8'h10
// ---------------------------------------------
// timing
// ---------------------------------------------
`define PTC_CLK_HZ 125000000
`define PTC_PUNCH_RATE_PER_S 60
`define PTC_PUNCH_GAP_CYCLES ((`PTC_CLK_HZ + `PTC_PUNCH_RATE_PER_S - 1) / `PTC_PUNCH_RATE_PER_S)
`endif

// >>> core/ptc_pkg.sv
// types shared by the tape controller modules
package ptc_pkg;
   typedef struct packed {
      logic valid;
      logic start;
      logic stop;
      logic inhibit;
      logic allow;
   } cmd_t;
   typedef enum logic [0:0] {TX_IDLE, TX_PUNCH} tx_state_t;
   typedef struct packed {
      logic allow;
      logic need;
      logic req;
      logic force_req;
   } sec_state_t;
endpackage : ptc_pkg

// >>> core/section_if.sv
// carrier between the controller and one interrupt section
`timescale 1ns/1ps
interface section_if;
   logic event_set;
   logic force_set;
   logic clr_xfer;
   logic clr_query;
   logic clr_status;
   logic do_inhibit;
   logic do_allow;
   logic irq;
   logic allowed;
   modport ctl (output event_set, force_set, clr_xfer, clr_query, clr_status,
      do_inhibit, do_allow, input irq, allowed);
   modport sec (input event_set, force_set, clr_xfer, clr_query, clr_status,
      do_inhibit, do_allow, output irq, allowed);
endinterface : section_if

// >>> tb/ptc_controller_sva.sv
// port-level assertions for the tape controller
`timescale 1ns/1ps
module ptc_controller_sva #(
   parameter logic [7:0] STATION_ADDR = 8'h10,
   parameter int unsigned PUNCH_GAP_CYCLES = 20
) (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic [7:0] dev_addr_i,
   input wire logic [15:0] bus_i,
   input wire logic cmd_strobe_i,
   input wire logic data_in_strobe_i,
   input wire logic data_out_strobe_i,
   input wire logic addr_in_strobe_i,
   input wire logic status_in_strobe_i,
   input wire logic rx_prio_i,
   input wire logic rdr_char_strobe_i,
   input wire logic [15:0] bus_o,
   input wire logic bus_oe_o,
   input wire logic ack_o,
   input wire logic rx_irq_o,
   input wire logic [7:0] pun_data_o,
   input wire logic pun_start_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!resetn_i);
   logic tx_a, rx_a, code_ok;
   logic [7:0] code;
   int unsigned gap_q;
   // the bus carries the msb on line 8
   function automatic logic [7:0] rev8(input logic [7:0] b);
      for (int i = 0; i < 8; i++) rev8[i] = b[7 - i];
   endfunction : rev8
   // address match and command decode
   assign tx_a = dev_addr_i == STATION_ADDR;
   assign rx_a = dev_addr_i == (STATION_ADDR | 8'h01);
   assign code = rev8(bus_i[15:8]);
   assign code_ok = code inside {8'h01, 8'h02, 8'h04, 8'h05, 8'h06, 8'h08, 8'h09, 8'h0a};
   // cycles since the last punch start; saturates so it never wraps
   always_ff @(posedge clock_i) begin
      if (!resetn_i) gap_q <= PUNCH_GAP_CYCLES;
      else if (pun_start_o) gap_q <= 0;
      else if (gap_q < PUNCH_GAP_CYCLES) gap_q <= gap_q + 1;
   end
   a_cmd_ack: assert property ((cmd_strobe_i && (tx_a || rx_a) && code_ok) |=> ack_o)
      else $error("valid command not acknowledged");
   a_cmd_nak: assert property ((cmd_strobe_i && !code_ok) |=> !ack_o)
      else $error("invalid command acknowledged");
   a_stat_noack: assert property ((status_in_strobe_i && (tx_a || rx_a))
      |=> bus_oe_o && !ack_o) else $error("status answer wrong");
   a_query_noack: assert property (addr_in_strobe_i |=> !ack_o)
      else $error("address query acknowledged");
   a_query_rx: assert property ((addr_in_strobe_i && rx_irq_o && rx_prio_i)
      |=> bus_oe_o && bus_o[15:8] == rev8(STATION_ADDR | 8'h01))
      else $error("receiver address not returned");
   a_punch_cause: assert property (pun_start_o |-> $past(data_out_strobe_i) && $past(tx_a))
      else $error("punch start without data-out");
   a_punch_gap: assert property (pun_start_o |-> gap_q >= PUNCH_GAP_CYCLES - 1)
      else $error("punch starts too close");
   a_punch_byte: assert property (pun_start_o |-> pun_data_o == rev8($past(bus_i[15:8])))
      else $error("punch byte differs from bus");
   a_stat_clr: assert property ((status_in_strobe_i && rx_a && !rdr_char_strobe_i)
      |=> !rx_irq_o) else $error("receiver request kept after status");
   a_read_lines: assert property ((data_in_strobe_i && rx_a)
      |=> bus_oe_o && bus_o[7:0] == 8'h00) else $error("read answer wrong");
endmodule : ptc_controller_sva
bind ptc_controller ptc_controller_sva #(.STATION_ADDR(STATION_ADDR),
   .PUNCH_GAP_CYCLES(PUNCH_GAP_CYCLES)) ptc_controller_sva_inst (.clock_i, .resetn_i,
   .dev_addr_i, .bus_i, .cmd_strobe_i, .data_in_strobe_i, .data_out_strobe_i,
   .addr_in_strobe_i, .status_in_strobe_i, .rx_prio_i, .rdr_char_strobe_i, .bus_o,
   .bus_oe_o, .ack_o, .rx_irq_o, .pun_data_o, .pun_start_o);

// >>> tb/ptc_controller_tb.sv
// self-checking bench for the tape controller
`timescale 1ns/1ps
`include "ptc_params.svh"
module ptc_controller_tb;
   localparam logic [7:0] TXA = 8'h10, RXA = 8'h11, Z = 8'h00;
   localparam logic Y = 1'b1, N = 1'b0;
   localparam int CMD = 0, DIN = 1, DOUT = 2, AIN = 3, SIN = 4;
   localparam int PST = 0, RUN = 1, TXI = 2, RXI = 3;
   typedef struct packed {logic ack; logic oe; logic [7:0] dat;} note_t;
   logic clock_i = 0, resetn_i = 0, rx_prio_i = 0, tx_prio_i = 1, feed = 0, took = 0;
   logic rdr_load_pos_i = 0, pun_near_end_i = 0, pun_done_i, rdr_char_strobe_i;
   logic rdr_rewinding_i = 0, pun_power_ok_i = 1;
   logic bus_oe_o, ack_o, rx_irq_o, tx_irq_o, rdr_run_o, pun_start_o;
   logic [4:0] strb = 5'h00;
   logic [7:0] dev_addr_i = 8'h00, ch = 8'h00, rdr_char_i, pun_data_o;
   logic [15:0] bus_i = 16'h0000, bus_o;
   wire [3:0] lv = {rx_irq_o, tx_irq_o, rdr_run_o, pun_start_o};
   string lvn[4] = '{"pun_start", "rdr_run", "tx_irq", "rx_irq"};
   logic [7:0] codes[8] = '{8'h01, 8'h02, 8'h04, 8'h05, 8'h06, 8'h08, 8'h09, 8'h0a};
   note_t exp_q[$];
   int fail_count = 0, num_checks = 0, seed = 19108;
   always #4 clock_i = ~clock_i;
   ptc_controller #(.STATION_ADDR(TXA), .PUNCH_GAP_CYCLES(20)) ptc_controller_inst (
      .clock_i, .resetn_i, .dev_addr_i, .bus_i, .cmd_strobe_i(strb[CMD]),
      .data_in_strobe_i(strb[DIN]), .data_out_strobe_i(strb[DOUT]),
      .addr_in_strobe_i(strb[AIN]), .status_in_strobe_i(strb[SIN]), .rx_prio_i,
      .tx_prio_i, .bus_o, .bus_oe_o, .ack_o, .rx_irq_o, .tx_irq_o, .rdr_char_strobe_i,
      .rdr_char_i, .rdr_power_ok_i(1'b1), .rdr_load_pos_i, .rdr_rewinding_i,
      .rdr_run_o, .pun_power_ok_i, .pun_out_of_tape_i(1'b0), .pun_near_end_i,
      .pun_done_i, .pun_data_o, .pun_start_o);
   tape_mech_model #(.PUNCH_CYCLES(8)) tape_mech_model_inst (.clock_i,
      .rdr_run_i(rdr_run_o), .feed_i(feed), .char_i(ch), .rdr_char_strobe_o(rdr_char_strobe_i),
      .rdr_char_o(rdr_char_i), .pun_start_i(pun_start_o), .pun_done_o(pun_done_i));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [7:0] rev8(input logic [7:0] b);
      for (int i = 0; i < 8; i++) rev8[i] = b[7 - i];
   endfunction : rev8
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : print_verdict
   // one strobe cycle; the answer is noted for the monitor
   task automatic op(input int k, input logic [7:0] a, b, input logic ea, eo,
      input logic [7:0] ed);
      exp_q.push_back('{ea, eo, ed});
      dev_addr_i <= a;
      bus_i <= {rev8(b), 8'h00};
      strb <= 5'h01 << k;
      @(posedge clock_i);
   endtask : op
   // level output checked n cycles after the last answer
   task automatic lvl(input int n, input int i, input logic e);
      strb <= 5'h00;
      repeat (n) @(posedge clock_i);
      @(negedge clock_i);
      check(lvn[i], {15'h0, lv[i]}, {15'h0, e});
      @(posedge clock_i);
   endtask : lvl
   task automatic feed_char();
      int r;
      r = $random(seed);
      strb <= 5'h00;
      ch <= r[7:0];
      feed <= Y;
      @(posedge clock_i);
      feed <= N;
      repeat (4) @(posedge clock_i);
   endtask : feed_char
   // bounded wait for the punch to finish
   task automatic wait_tx();
      strb <= 5'h00;
      for (int i = 0; i < 60 && tx_irq_o !== 1'b1; i++) @(negedge clock_i);
      check("tx_irq_wait", {15'h0, tx_irq_o}, 16'h0001);
      if (tx_irq_o !== 1'b1) print_verdict();
      @(posedge clock_i);
   endtask : wait_tx
   // the design takes a strobe at this edge and answers one cycle later
   always @(posedge clock_i) took <= |strb;
   always @(negedge clock_i) begin
      note_t n;
      if (took) begin
         if (exp_q.size() == 0) check("queue", 16'h0, 16'h1);
         else begin
            n = exp_q.pop_front();
            check("ack", {15'h0, ack_o}, {15'h0, n.ack});
            check("oe", {15'h0, bus_oe_o}, {15'h0, n.oe});
            if (n.oe) check("bus", bus_o, {rev8(n.dat), 8'h00});
         end
      end
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (5) @(posedge clock_i);
      resetn_i <= Y;
      @(negedge clock_i);
      check("reset", {10'h0, lv, ack_o, bus_oe_o}, 16'h0);
      @(posedge clock_i);
      // all codes, bad codes, foreign address
      foreach (codes[i]) op(CMD, TXA, codes[i], Y, N, Z);
      op(CMD, TXA, 8'h03, N, N, Z);
      op(CMD, RXA, 8'h80, N, N, Z);
      op(SIN, 8'h12, Z, N, N, Z);
      lvl(2, RUN, N);
      $display("test commands done");
      op(CMD, RXA, `PTC_CMD_START, Y, N, Z);
      lvl(1, RUN, Y);
      feed_char();
      lvl(0, RXI, N);
      op(DIN, RXA, Z, Y, Y, ch);
      op(DIN, RXA, Z, N, Y, ch);
      op(AIN, Z, Z, N, N, Z);
      feed_char();
      feed_char();
      op(DIN, RXA, Z, N, Y, ch);
      feed_char();
      op(DIN, RXA, Z, N, Y, ch);
      op(SIN, RXA, Z, N, Y, `PTC_STAT_TIMING_ERR);
      op(SIN, RXA, Z, N, Y, `PTC_STAT_NONE);
      // the char that arrived during the error is still unread, so it is owed
      op(DIN, RXA, Z, Y, Y, ch);
      feed_char();
      op(DIN, RXA, Z, Y, Y, ch);
      feed_char();
      feed_char();
      op(DIN, RXA, Z, N, Y, ch);
      op(CMD, RXA, `PTC_CMD_START_ALW, Y, N, Z);
      op(SIN, RXA, Z, N, Y, `PTC_STAT_NONE);
      $display("test reader done");
      feed_char();
      lvl(0, RXI, Y);
      op(CMD, RXA, `PTC_CMD_START_INH, Y, N, Z);
      lvl(1, RXI, N);
      op(CMD, RXA, `PTC_CMD_ALLOW, Y, N, Z);
      lvl(1, RXI, Y);
      op(AIN, Z, Z, N, N, Z);
      rx_prio_i <= Y;
      op(AIN, Z, Z, N, Y, RXA);
      lvl(1, RXI, N);
      op(DIN, RXA, Z, Y, Y, ch);
      op(CMD, RXA, `PTC_CMD_STOP_INH, Y, N, Z);
      lvl(1, RUN, Y);
      feed_char();
      lvl(0, RUN, N);
      op(DIN, RXA, Z, Y, Y, ch);
      rdr_load_pos_i <= Y;
      op(CMD, RXA, `PTC_CMD_START, Y, N, Z);
      lvl(1, RXI, Y);
      op(SIN, RXA, Z, N, Y, `PTC_STAT_NOT_READY);
      lvl(1, RXI, N);
      rdr_load_pos_i <= N;
      op(SIN, RXA, Z, N, Y, `PTC_STAT_NOT_READY);
      op(SIN, RXA, Z, N, Y, `PTC_STAT_NONE);
      // a rewind pulse alone must leave the not-ready flag behind
      rdr_rewinding_i <= Y;
      lvl(0, RXI, N);
      rdr_rewinding_i <= N;
      op(SIN, RXA, Z, N, Y, `PTC_STAT_NOT_READY);
      $display("test interrupts done");
      op(DOUT, TXA, ch, Y, N, Z);
      op(DOUT, TXA, ~ch, N, N, Z);
      lvl(0, PST, N);
      check("pun_data", {8'h0, pun_data_o}, {8'h0, ch});
      wait_tx();
      idle_gap();
      op(DOUT, TXA, ch, Y, N, Z);
      lvl(0, TXI, N);
      wait_tx();
      rx_prio_i <= N;
      op(AIN, Z, Z, N, Y, TXA);
      lvl(1, TXI, N);
      idle_gap();
      pun_near_end_i <= Y;
      op(DOUT, TXA, ch, N, N, Z);
      lvl(0, PST, Y);
      lvl(0, TXI, Y);
      op(SIN, TXA, Z, N, Y, `PTC_STAT_NOT_READY);
      lvl(1, TXI, N);
      pun_near_end_i <= N;
      idle_gap();
      op(SIN, TXA, Z, N, Y, `PTC_STAT_NOT_READY);
      op(SIN, TXA, Z, N, Y, `PTC_STAT_NONE);
      pun_power_ok_i <= N;
      op(SIN, TXA, Z, N, Y, `PTC_STAT_NOT_READY);
      lvl(2, PST, N);
      $display("test punch done");
      print_verdict();
   end
   // the punch pace timer needs a full gap before the next byte
   task automatic idle_gap();
      strb <= 5'h00;
      repeat (24) @(posedge clock_i);
   endtask : idle_gap
endmodule : ptc_controller_tb

// >>> tb/tape_mech_model.sv
// behavioural tape reader and punch on the controller's far side
`timescale 1ns/1ps
module tape_mech_model #(
   parameter int unsigned PUNCH_CYCLES = 8
) (
   input wire logic clock_i,
   input wire logic rdr_run_i,
   input wire logic feed_i,
   input wire logic [7:0] char_i,
   output logic rdr_char_strobe_o,
   output logic [7:0] rdr_char_o,
   input wire logic pun_start_i,
   output logic pun_done_o
);
   int unsigned busy_q = 0;
   initial begin
      rdr_char_strobe_o = 1'b0;
      rdr_char_o = 8'h00;
      pun_done_o = 1'b0;
   end
   // strobe with each byte
   // tape only moves while run is high; idle byte lines toggle so stale data is never valid
   always @(posedge clock_i) begin
      rdr_char_strobe_o <= feed_i && rdr_run_i;
      rdr_char_o <= (feed_i && rdr_run_i) ? char_i : ~rdr_char_o;
   end
   always @(posedge clock_i) begin
      pun_done_o <= busy_q == 1;
      if (pun_start_i) busy_q <= PUNCH_CYCLES;
      else if (busy_q != 0) busy_q <= busy_q - 1;
   end
endmodule : tape_mech_model
